// ==== include/acr_consts.svh ====
// Constants for the converter configuration and test pattern register slice.
// Assumes inclusion by bare name from the package and bench files.
// Functional notes
// - Input control bit 5 picks channel A input mode, 0 differential and 1 single-ended.
// - On the fastest grade, loop power-down bit 2 at 0 gives a quarter-period sampling window, at 1 the loop is off and the window follows the clock duty cycle.
// - Input control bit 0 enables auto-zero, resetting to 1 on slower grades and 0 on the fastest.
// - A fuse-map load reloads the output bit mapping and returns earlier serial-port register writes to defaults.
// - An 18-bit pattern value spans low byte, middle byte and bits 1-0 of the third register, used MSB-aligned as the constant pattern.
// - In ramp mode the pattern value is the ramp step, 00001 for 18-bit, 00100 for 16-bit and 10000 for 14-bit resolution.
// - The 3-bit channel A selector picks 000 converter data, 010 ramp, 011 constant value, other codes unused.
// - The test pattern enters ahead of the bit mapper at native resolution, aligned from the MSB.
// - Pattern substitution behaves the same in every output format with no format-specific setting.
// - When enabled the bit mapper sets output resolution from a 3-bit code, 000 18-bit, 001 16-bit, 010 14-bit.
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

`define ACR_ADDR_W        7
`define ACR_OFS_INPUT     7'h11
`define ACR_OFS_FUSE      7'h13
`define ACR_OFS_PAT_LO    7'h14
`define ACR_OFS_PAT_MID   7'h15
`define ACR_OFS_PAT_HI    7'h16

`define ACR_BIT_SE        5
`define ACR_BIT_DLL       2
`define ACR_BIT_AZ        0
`define ACR_BIT_FUSE      0
`define ACR_SEL_MSB       4
`define ACR_SEL_LSB       2
`define ACR_PATHI_MSB     1
`define ACR_PATHI_LSB     0

`define ACR_INPUT_RST_SLOW 8'h01
`define ACR_INPUT_RST_FAST 8'h00
`define ACR_BYTE_RST      8'h00
`define ACR_PAT_RST       18'h00000

`define ACR_SEL_NORMAL    3'h0
`define ACR_SEL_RAMP      3'h2
`define ACR_SEL_CONST     3'h3

`define ACR_RES_18        3'h0
`define ACR_RES_16        3'h1
`define ACR_RES_14        3'h2

`define ACR_FRAME_BITS    5'h10
`define ACR_ADDR_BITS     5'h08

`endif

// ==== include/acr_pkg.sv ====
// Types shared by the register slice and its serial port.
// Assumes the constants header sits on the include path.
`include "acr_consts.svh"
package acr_pkg;
	typedef logic [7:0]              acr_byte_t;
	typedef logic [`ACR_ADDR_W-1:0] acr_addr_t;
	typedef logic [17:0]             acr_word18_t;
	typedef logic [2:0]              acr_code_t;
	typedef logic [4:0]              acr_count_t;
endpackage : acr_pkg

// ==== hw/acr_spi_slave.sv ====
// Serial configuration port: 16-bit frames, read flag, 7-bit address, 8-bit data.
// Assumes serial pins synchronous to clk and far slower than it.
`timescale 1ns/1ns
module acr_spi_slave
	import acr_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      sys_rst,
	input  wire logic      spi_sen_n,
	input  wire logic      spi_sclk,
	input  wire logic      spi_sdi,
	output logic           spi_sdo,
	output logic           spi_sdo_oe_n,
	output acr_addr_t      rd_addr,
	input  wire acr_byte_t rd_data,
	output logic           wr_stb,
	output acr_addr_t      wr_addr,
	output acr_byte_t      wr_data
);
	logic       sclk_reg;
	logic [15:0] shift_reg;
	acr_count_t count_reg;
	acr_byte_t  out_reg;
	logic       rise;
	logic       fall;
	logic       rd_flag_reg;

	assign rise         = spi_sclk & ~sclk_reg & ~spi_sen_n;
	assign fall         = ~spi_sclk & sclk_reg & ~spi_sen_n;
	assign rd_addr      = {shift_reg[5:0], spi_sdi};
	assign spi_sdo      = out_reg[7];
	// Read flag held for the whole frame, not taken from the moving shift register
	assign spi_sdo_oe_n = ~(~spi_sen_n & rd_flag_reg & (count_reg >= `ACR_ADDR_BITS)
		& (count_reg < `ACR_FRAME_BITS));

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sclk_reg <= 1'b0;
		else
			sclk_reg <= spi_sclk;
	end

	// Shift in and count bits
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			shift_reg   <= 16'h0000;
			count_reg   <= 5'h00;
			rd_flag_reg <= 1'b0;
		end
		else if (spi_sen_n)
			count_reg <= 5'h00;
		else if (rise && count_reg < `ACR_FRAME_BITS)
		begin
			if (count_reg == 5'h00)
				rd_flag_reg <= spi_sdi;
			shift_reg <= {shift_reg[14:0], spi_sdi};
			count_reg <= count_reg + 5'h01;
		end
	end

	// Read data loaded after address, shifted on falling edges
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			out_reg <= 8'h00;
		else if (rise && count_reg == `ACR_ADDR_BITS - 5'h01)
			out_reg <= rd_data;
		else if (fall && count_reg >= `ACR_ADDR_BITS)
			out_reg <= {out_reg[6:0], 1'b0};
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_stb  <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
		end
		else
		begin
			wr_stb <= rise && count_reg == `ACR_FRAME_BITS - 5'h01 && !shift_reg[14];
			if (rise && count_reg == `ACR_FRAME_BITS - 5'h01)
			begin
				wr_addr <= shift_reg[13:7];
				wr_data <= {shift_reg[6:0], spi_sdi};
			end
		end
	end
endmodule : acr_spi_slave

// ==== hw/acr_regs.sv ====
// Configuration registers, fuse-map load and channel A test pattern path.
// Assumes converter samples arrive with a one-cycle sample_valid enable.
`timescale 1ns/1ns
module acr_regs
	import acr_pkg::*;
#(
	parameter bit FAST_GRADE = 1'b0
)
(
	input  wire logic      clk,
	input  wire logic      sys_rst,
	input  wire logic      spi_sen_n,
	input  wire logic      spi_sclk,
	input  wire logic      spi_sdi,
	output logic           spi_sdo,
	output logic           spi_sdo_oe_n,
	input  wire logic [13:0] adc_data,
	input  wire logic      sample_valid,
	input  wire logic      mapper_enable,
	input  wire acr_code_t output_resolution_code,
	output logic           single_ended_input_sel,
	output logic           delay_loop_power_down,
	output logic           sample_window_half,
	output logic           auto_zero_enable,
	output logic           fuse_map_load_stb,
	output acr_word18_t    test_data,
	output acr_word18_t    mapped_data
);
	localparam acr_byte_t INPUT_RST = FAST_GRADE ? `ACR_INPUT_RST_FAST : `ACR_INPUT_RST_SLOW;

	acr_addr_t   rd_addr;
	acr_byte_t   rd_data;
	logic        wr_stb;
	acr_addr_t   wr_addr;
	acr_byte_t   wr_data;
	acr_byte_t   input_reg;
	logic        fuse_reg;
	acr_byte_t   pat_lo_reg;
	acr_byte_t   pat_mid_reg;
	logic [1:0]  pat_hi_reg;
	acr_code_t   sel_reg;
	acr_word18_t pattern_value;
	acr_word18_t ramp_reg;
	acr_word18_t ramp_next;
	logic        fuse_release;

	acr_spi_slave i_acr_spi_slave
	(
		.clk          (clk),
		.sys_rst      (sys_rst),
		.spi_sen_n    (spi_sen_n),
		.spi_sclk     (spi_sclk),
		.spi_sdi      (spi_sdi),
		.spi_sdo      (spi_sdo),
		.spi_sdo_oe_n (spi_sdo_oe_n),
		.rd_addr      (rd_addr),
		.rd_data      (rd_data),
		.wr_stb       (wr_stb),
		.wr_addr      (wr_addr),
		.wr_data      (wr_data)
	);

	// Load completes on the 1 to 0 write of the load bit
	assign fuse_release = wr_stb && wr_addr == `ACR_OFS_FUSE
		&& !wr_data[`ACR_BIT_FUSE] && fuse_reg;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fuse_reg          <= 1'b0;
			fuse_map_load_stb <= 1'b0;
		end
		else
		begin
			fuse_map_load_stb <= fuse_release;
			if (wr_stb && wr_addr == `ACR_OFS_FUSE)
				fuse_reg <= wr_data[`ACR_BIT_FUSE];
		end
	end

	// Input control; returned to its reset value by a fuse-map load
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			input_reg <= INPUT_RST;
		else if (fuse_release)
			input_reg <= INPUT_RST;
		else if (wr_stb && wr_addr == `ACR_OFS_INPUT)
		begin
			input_reg                 <= 8'h00;
			input_reg[`ACR_BIT_SE]  <= wr_data[`ACR_BIT_SE];
			input_reg[`ACR_BIT_DLL] <= wr_data[`ACR_BIT_DLL];
			input_reg[`ACR_BIT_AZ]  <= wr_data[`ACR_BIT_AZ];
		end
	end

	assign single_ended_input_sel = input_reg[`ACR_BIT_SE];
	assign auto_zero_enable       = input_reg[`ACR_BIT_AZ];
	assign delay_loop_power_down  = FAST_GRADE & input_reg[`ACR_BIT_DLL];
	assign sample_window_half     = delay_loop_power_down;

	// Pattern value and selector; cleared by a fuse-map load
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pat_lo_reg  <= `ACR_BYTE_RST;
			pat_mid_reg <= `ACR_BYTE_RST;
			pat_hi_reg  <= 2'h0;
			sel_reg     <= `ACR_SEL_NORMAL;
		end
		else if (fuse_release)
		begin
			pat_lo_reg  <= `ACR_BYTE_RST;
			pat_mid_reg <= `ACR_BYTE_RST;
			pat_hi_reg  <= 2'h0;
			sel_reg     <= `ACR_SEL_NORMAL;
		end
		else if (wr_stb)
		begin
			if (wr_addr == `ACR_OFS_PAT_LO)
				pat_lo_reg <= wr_data;
			if (wr_addr == `ACR_OFS_PAT_MID)
				pat_mid_reg <= wr_data;
			if (wr_addr == `ACR_OFS_PAT_HI)
			begin
				pat_hi_reg <= wr_data[`ACR_PATHI_MSB:`ACR_PATHI_LSB];
				sel_reg    <= wr_data[`ACR_SEL_MSB:`ACR_SEL_LSB];
			end
		end
	end

	assign pattern_value = {pat_hi_reg, pat_mid_reg, pat_lo_reg};

	// Register readback, reserved bits and unmapped addresses read zero
	always_comb
	begin
		case (rd_addr)
			`ACR_OFS_INPUT:   rd_data = input_reg;
			`ACR_OFS_FUSE:    rd_data = {7'h00, fuse_reg};
			`ACR_OFS_PAT_LO:  rd_data = pat_lo_reg;
			`ACR_OFS_PAT_MID: rd_data = pat_mid_reg;
			`ACR_OFS_PAT_HI:  rd_data = {3'h0, sel_reg, pat_hi_reg};
			default:          rd_data = 8'h00;
		endcase
	end

	// Ramp accumulator, one step per sample
	assign ramp_next = ramp_reg + pattern_value;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ramp_reg <= `ACR_PAT_RST;
		else if (sel_reg != `ACR_SEL_RAMP)
			ramp_reg <= `ACR_PAT_RST;
		else if (sample_valid)
			ramp_reg <= ramp_next;
	end

	// Source select ahead of the mapper, same for every output format
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			test_data <= `ACR_PAT_RST;
		else if (sample_valid)
		begin
			case (sel_reg)
				`ACR_SEL_RAMP:  test_data <= ramp_reg;
				`ACR_SEL_CONST: test_data <= pattern_value;
				default:        test_data <= {adc_data, 4'h0};
			endcase
		end
	end

	// Output bit mapper resolution
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			mapped_data <= `ACR_PAT_RST;
		else if (!mapper_enable)
			mapped_data <= test_data;
		else
		begin
			case (output_resolution_code)
				`ACR_RES_16: mapped_data <= {test_data[17:2], 2'h0};
				`ACR_RES_14: mapped_data <= {test_data[17:4], 4'h0};
				default:     mapped_data <= test_data;
			endcase
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_input_write;
		wr_stb && wr_addr == `ACR_OFS_INPUT && !fuse_release;
	endsequence

	sequence s_fuse_release;
		wr_stb && wr_addr == `ACR_OFS_FUSE && !wr_data[`ACR_BIT_FUSE] ##0 fuse_reg;
	endsequence

	sequence s_ramp_tick;
		sel_reg == `ACR_SEL_RAMP && sample_valid && !fuse_release
			&& !(wr_stb && wr_addr == `ACR_OFS_PAT_HI);
	endsequence

	a_se_mode_write: assert property (s_input_write |=>
		single_ended_input_sel == $past(wr_data[`ACR_BIT_SE]))
		else $error("single-ended select does not follow write");

	a_auto_zero_write: assert property (s_input_write |=>
		auto_zero_enable == $past(wr_data[`ACR_BIT_AZ]))
		else $error("auto-zero enable does not follow write");

	a_dll_window_tie: assert property (sample_window_half ==
		(FAST_GRADE && input_reg[`ACR_BIT_DLL]))
		else $error("sampling window does not follow loop power-down");

	a_fuse_load_pulse: assert property (s_fuse_release |=> fuse_map_load_stb
		##1 !fuse_map_load_stb)
		else $error("fuse-map load pulse missing or too long");

	a_fuse_clears_regs: assert property (fuse_map_load_stb |->
		pattern_value == `ACR_PAT_RST && sel_reg == `ACR_SEL_NORMAL && input_reg == INPUT_RST)
		else $error("fuse-map load left earlier writes in place");

	a_const_pattern: assert property (sel_reg == `ACR_SEL_CONST && sample_valid |=>
		test_data == $past(pattern_value))
		else $error("constant pattern not output");

	a_ramp_step: assert property (s_ramp_tick |=>
		ramp_reg == 18'($past(ramp_reg) + $past(pattern_value)))
		else $error("ramp did not advance by one step");

	a_normal_data: assert property (sel_reg == `ACR_SEL_NORMAL && sample_valid |=>
		test_data == {$past(adc_data), 4'h0})
		else $error("converter data not MSB aligned");

	a_mapper_14bit: assert property (mapper_enable && output_resolution_code == `ACR_RES_14
		|=> mapped_data == {$past(test_data[17:4]), 4'h0})
		else $error("14-bit mapping wrong");

	a_mapper_16bit: assert property (mapper_enable && output_resolution_code == `ACR_RES_16
		|=> mapped_data == {$past(test_data[17:2]), 2'h0})
		else $error("16-bit mapping wrong");

	a_ramp_output: assert property (sel_reg == `ACR_SEL_RAMP && sample_valid |=>
		test_data == $past(ramp_reg))
		else $error("ramp pattern not output");
endmodule : acr_regs

// ==== bench/acr_host_model.sv ====
// Host side of the serial configuration port: one frame per call.
// Assumes clk of the device; sclk each level held two clk cycles.
`timescale 1ns/1ns
module acr_host_model
	import acr_pkg::*;
(
	input  wire logic clk,
	output logic      spi_sen_n,
	output logic      spi_sclk,
	output logic      spi_sdi,
	input  wire logic spi_sdo
);
	initial
	begin
		spi_sen_n = 1'h1;
		spi_sclk  = 1'h0;
		spi_sdi   = 1'h0;
	end

	// Frame MSB first, sclk idle low, read bits taken in high phase of rises 8 to 15
	task automatic xfer(input logic rd, input acr_addr_t a, input acr_byte_t d,
		output acr_byte_t q);
		logic [15:0] frame;
		frame = {rd, a, d};
		q     = 8'h00;
		@(negedge clk);
		spi_sen_n = 1'h0;
		for (int i = 15; i >= 0; i--)
		begin
			spi_sdi = frame[i];
			repeat (2) @(negedge clk);
			spi_sclk = 1'h1;
			repeat (2) @(negedge clk);
			if (i >= 1 && i <= 8)
				q[i-1] = spi_sdo;
			spi_sclk = 1'h0;
		end
		repeat (2) @(negedge clk);
		spi_sen_n = 1'h1;
		spi_sdi   = ~spi_sdi;
		repeat (2) @(negedge clk);
	endtask : xfer
endmodule : acr_host_model

// ==== bench/acr_regs_bench.sv ====
// Bench for the register slice, fastest grade, host model on the serial port.
// Assumes the constants header on the include path.
`timescale 1ns/1ns
`include "acr_consts.svh"
module acr_regs_bench
	import acr_pkg::*;
;
	logic        clk, sys_rst, spi_sen_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n;
	logic [13:0] adc_data;
	logic        sample_valid, mapper_enable;
	acr_code_t   output_resolution_code;
	logic        single_ended_input_sel, delay_loop_power_down, sample_window_half;
	logic        auto_zero_enable, fuse_map_load_stb;
	acr_word18_t test_data, mapped_data;
	acr_byte_t   rdat;
	int          mismatches, comparisons, fuse_pulses;
	int          oe_cycles = 0;
	int          oe_mark;
	acr_word18_t steps [4] = '{18'h00001, 18'h00004, 18'h00010, 18'h3FFFF};

	acr_regs #(.FAST_GRADE(1'h1)) i_acr_regs (
		.clk(clk), .sys_rst(sys_rst), .spi_sen_n(spi_sen_n), .spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
		.adc_data(adc_data), .sample_valid(sample_valid), .mapper_enable(mapper_enable),
		.output_resolution_code(output_resolution_code),
		.single_ended_input_sel(single_ended_input_sel),
		.delay_loop_power_down(delay_loop_power_down),
		.sample_window_half(sample_window_half), .auto_zero_enable(auto_zero_enable),
		.fuse_map_load_stb(fuse_map_load_stb), .test_data(test_data),
		.mapped_data(mapped_data));

	acr_host_model i_acr_host_model (.clk(clk), .spi_sen_n(spi_sen_n),
		.spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

	always #10 clk = ~clk;

	always @(posedge clk)
		if (fuse_map_load_stb === 1'h1)
			fuse_pulses++;

	always @(posedge clk)
		if (spi_sdo_oe_n === 1'h0)
			oe_cycles++;

	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input acr_addr_t a, input acr_byte_t d);
		i_acr_host_model.xfer(1'h0, a, d, rdat);
	endtask : wr

	task automatic rd(input acr_addr_t a, input acr_byte_t exp);
		i_acr_host_model.xfer(1'h1, a, 8'h00, rdat);
		chk({10'h000, rdat}, {10'h000, exp});
	endtask : rd

	// One sample; pattern output one cycle on, mapper output one more
	task automatic samp(input logic [13:0] d, input acr_word18_t exp);
		@(negedge clk);
		adc_data     = d;
		sample_valid = 1'h1;
		@(negedge clk);
		sample_valid = 1'h0;
		chk(test_data, exp);
		@(negedge clk);
		chk(mapped_data, exp);
	endtask : samp

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end

	initial
	begin
		clk = 1'h0;
		sys_rst = 1'h1;
		adc_data = 14'h0000;
		sample_valid = 1'h0;
		mapper_enable = 1'h0;
		output_resolution_code = 3'h0;
		mismatches = 0;
		comparisons = 0;
		fuse_pulses = 0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'h0;
		chk({17'h00000, auto_zero_enable}, 18'h00000);
		rd(`ACR_OFS_INPUT, `ACR_INPUT_RST_FAST);
		rd(`ACR_OFS_PAT_HI, `ACR_BYTE_RST);
		rd(7'h20, 8'h00);
		wr(`ACR_OFS_INPUT, 8'h25);
		chk({14'h0000, single_ended_input_sel, delay_loop_power_down,
			sample_window_half, auto_zero_enable}, 18'h0000F);
		rd(`ACR_OFS_INPUT, 8'h25);
		wr(`ACR_OFS_INPUT, 8'hDA);
		chk({14'h0000, single_ended_input_sel, delay_loop_power_down,
			sample_window_half, auto_zero_enable}, 18'h00000);
		rd(`ACR_OFS_INPUT, 8'h00);
		samp(14'h2ABC, {14'h2ABC, 4'h0});
		wr(`ACR_OFS_PAT_LO, 8'h56);
		wr(`ACR_OFS_PAT_MID, 8'h34);
		wr(`ACR_OFS_PAT_HI, 8'h0E);
		rd(`ACR_OFS_PAT_HI, 8'h0E);
		samp(14'h1111, 18'h23456);
		mapper_enable = 1'h1;
		output_resolution_code = `ACR_RES_16;
		@(negedge clk);
		chk(mapped_data, 18'h23454);
		output_resolution_code = `ACR_RES_14;
		@(negedge clk);
		chk(mapped_data, 18'h23450);
		mapper_enable = 1'h0;
		output_resolution_code = `ACR_RES_18;
		wr(`ACR_OFS_PAT_HI, 8'h06);
		samp(14'h0123, {14'h0123, 4'h0});
		foreach (steps[k])
		begin
			wr(`ACR_OFS_PAT_HI, {6'h00, steps[k][17:16]});
			wr(`ACR_OFS_PAT_LO, steps[k][7:0]);
			wr(`ACR_OFS_PAT_MID, steps[k][15:8]);
			wr(`ACR_OFS_PAT_HI, {3'h0, `ACR_SEL_RAMP, steps[k][17:16]});
			for (int n = 0; n < 3; n++)
				samp(14'h3FFF, acr_word18_t'(steps[k] * n));
		end
		wr(`ACR_OFS_INPUT, 8'h21);
		wr(`ACR_OFS_PAT_LO, 8'hA5);
		wr(`ACR_OFS_FUSE, 8'h01);
		chk(18'(fuse_pulses), 18'h00000);
		wr(`ACR_OFS_FUSE, 8'h00);
		chk(18'(fuse_pulses), 18'h00001);
		rd(`ACR_OFS_INPUT, `ACR_INPUT_RST_FAST);
		rd(`ACR_OFS_PAT_LO, 8'h00);
		rd(`ACR_OFS_PAT_HI, 8'h00);
		samp(14'h0F0F, {14'h0F0F, 4'h0});
		oe_mark = oe_cycles;
		wr(`ACR_OFS_PAT_MID, 8'h5A);
		chk(18'(oe_cycles - oe_mark), 18'h00000);
		oe_mark = oe_cycles;
		rd(`ACR_OFS_PAT_MID, 8'h5A);
		chk(18'(oe_cycles - oe_mark), 18'h00020);
		chk({17'h00000, spi_sdo_oe_n}, 18'h00001);
		results();
	end
endmodule : acr_regs_bench
